/* File: shared/rsa_map.vh */
`ifndef RSA_MAP_VH
`define RSA_MAP_VH
// operation codes on i_op_code
`define RSA_OP_RL_THRU_C_TO_WORK  5'h00
`define RSA_OP_RR_CIRCULAR        5'h01
`define RSA_OP_RR_TO_WORK         5'h02
`define RSA_OP_RR_THRU_C          5'h03
`define RSA_OP_RR_THRU_C_TO_WORK  5'h04
`define RSA_OP_SUB_BORROW_MEM     5'h05
`define RSA_OP_SUB_BORROW_IMM     5'h06
`define RSA_OP_SUB_BORROW_TO_MEM  5'h07
`define RSA_OP_SUB_MEM            5'h08
`define RSA_OP_SUB_IMM            5'h09
`define RSA_OP_DIFF_TO_MEM        5'h0a
`define RSA_OP_DEC_SKIP           5'h0b
`define RSA_OP_DEC_SKIP_TO_WORK   5'h0c
`define RSA_OP_INC_SKIP           5'h0d
`define RSA_OP_INC_SKIP_TO_WORK   5'h0e
`define RSA_OP_SET_BYTE           5'h0f
`define RSA_OP_SET_BIT            5'h10
`define RSA_OP_SKIP_BIT_NONNULL   5'h11
`define RSA_OP_SKIP_NONNULL       5'h12
`define RSA_OP_SKIP_NULL          5'h13
`define RSA_OP_SKIP_NULL_TO_WORK  5'h14
`define RSA_OP_NIBBLE_EXCH        5'h15
`define RSA_OP_NIBBLE_EXCH_TO_WRK 5'h16
// apb register byte offsets
`define RSA_REG_WORK   12'h000
`define RSA_REG_FLAGS  12'h004
`define RSA_REG_CTRL   12'h008
`define RSA_REG_STATUS 12'h00c
// flag register bit positions
`define RSA_FLG_C  0
`define RSA_FLG_Z  1
`define RSA_FLG_OV 2
`define RSA_FLG_AC 3
`define RSA_FLG_SC 4
`define RSA_FLG_CZ 5
// reset values and the all-ones byte constant
`define RSA_WORK_RST  8'h00
`define RSA_FLAGS_RST 6'h00
`define RSA_CTRL_RST  1'b1
`define RSA_ALL_ONES  8'hff
`endif

/* File: verilog/rsa_alu.v */
// Contract
// (RULE_01) rotate left thru carry, result to work
// (RULE_02) circular rotate right back to memory
// (RULE_03) circular rotate right into work register
// (RULE_04) rotate right thru carry to memory
// (RULE_05) rotate right thru carry into work
// (RULE_06) work minus memory minus inverted carry
// (RULE_07) work minus immediate minus inverted carry
// (RULE_08) borrow subtract result goes to memory
// (RULE_09) plain subtract, work or memory destination
// (RULE_10) carry set unless difference is negative
// (RULE_11) subtracts update six status flags
// (RULE_12) decrement to memory, skip on zero
// (RULE_13) decrement into work, skip on zero
// (RULE_14) increment to memory, skip on zero
// (RULE_15) increment into work, skip on zero
// (RULE_16) skip instructions take two cycles
// (RULE_17) byte set all ones, bit set one
// (RULE_18) skip when selected bit is nonzero
// (RULE_19) skip when byte is nonzero
// (RULE_20) skip when byte is zero
// (RULE_21) nibble exchange written back to memory
// (RULE_22) nibble exchange into work register
// (RULE_23) skipped instruction has no effect
`timescale 1ns/100ps
`include "rsa_map.vh"

module rsa_alu (
   // clock and reset
   input  wire        i_core_clk,
   input  wire        i_rst,
   // apb slave
   input  wire        i_psel,
   input  wire        i_penable,
   input  wire        i_pwrite,
   input  wire [11:0] i_paddr,
   input  wire [31:0] i_pwdata,
   output reg  [31:0] o_prdata,
   output wire        o_pready,
   output wire        o_pslverr,
   // instruction request from sequencer
   input  wire        i_op_valid,
   input  wire [4:0]  i_op_code,
   input  wire [7:0]  i_mem_data,
   input  wire [7:0]  i_imm,
   input  wire [2:0]  i_bit_sel,
   output wire        o_op_ready,
   // results
   output reg         o_mem_we_q,
   output reg  [7:0]  o_mem_wdata_q,
   output reg         o_skip_q,
   output reg         o_squash_q,
   output wire [7:0]  o_work_q,
   output wire [5:0]  o_flags_q
);

   // architectural and control registers
   reg  [7:0] work_q;
   reg  [7:0] work_d;
   reg  [5:0] flags_q;
   reg  [5:0] flags_d;
   reg        enable_q;
   reg        dummy_q;
   reg        skip_pend_q;

   // decode results for the instruction on the request port
   reg        mem_we_d;
   reg  [7:0] mem_wdata_d;
   reg        skip_d;
   reg        is_skip_op;

   // subtract datapath and bit mask
   reg  [7:0] sub_b;
   reg        sub_borrow;
   reg        sub_op;
   reg        sub_keep_cz;
   reg  [8:0] diff9;
   reg  [4:0] diff_lo;
   reg  [7:0] diff;
   reg  [7:0] bit_mask;

   // handshake and bus helpers
   reg [31:0] rd_mux;
   wire       carry;
   wire       take;
   wire       apb_wr;
   wire       apb_hit;

   assign carry    = flags_q[`RSA_FLG_C];
   assign o_work_q = work_q;
   assign o_flags_q = flags_q;

   // ready unless disabled or in the dummy cycle after a skip instruction
   assign o_op_ready = enable_q & ~dummy_q; // RULE_16
   assign take       = i_op_valid & o_op_ready;

   // one-hot mask for bit operations
   always @* begin
      bit_mask = 8'h01 << i_bit_sel;
   end

   // subtract operand and borrow selection
   always @* begin
      sub_op      = 1'b1;
      sub_keep_cz = 1'b0;
      sub_b       = i_mem_data;
      sub_borrow  = 1'b0;
      case (i_op_code)
         // borrow forms take the inverted carry, operand from memory
         `RSA_OP_SUB_BORROW_MEM,
         `RSA_OP_SUB_BORROW_TO_MEM: begin
            sub_borrow  = ~carry; // RULE_06 RULE_08
            sub_keep_cz = 1'b1;
         end
         // borrow form with the immediate operand
         `RSA_OP_SUB_BORROW_IMM: begin
            sub_b       = i_imm;
            sub_borrow  = ~carry; // RULE_07
            sub_keep_cz = 1'b1;
         end
         // plain subtract of the memory byte, no borrow in
         `RSA_OP_SUB_MEM,
         `RSA_OP_DIFF_TO_MEM: begin
            sub_borrow = 1'b0; // RULE_09
         end
         // plain subtract of the immediate
         `RSA_OP_SUB_IMM: begin
            sub_b = i_imm; // RULE_09
         end
         // not a subtract: flags are left to the decode below
         default: begin
            sub_op = 1'b0;
         end
      endcase
   end

   // nine-bit difference and low nibble borrow
   always @* begin
      diff9   = {1'b0, work_q} - {1'b0, sub_b} - {8'h00, sub_borrow};
      diff_lo = {1'b0, work_q[3:0]} - {1'b0, sub_b[3:0]} - {4'h0, sub_borrow};
      diff    = diff9[7:0];
   end

   // operation decode: next work, flags, memory write and skip
   always @* begin
      work_d      = work_q;
      flags_d     = flags_q;
      mem_we_d    = 1'b0;
      mem_wdata_d = 8'h00;
      skip_d      = 1'b0;
      is_skip_op  = 1'b0;
      case (i_op_code)
         // nine-bit rotate left through carry, byte lands in work
         `RSA_OP_RL_THRU_C_TO_WORK: begin
            work_d                = {i_mem_data[6:0], carry}; // RULE_01
            flags_d[`RSA_FLG_C]   = i_mem_data[7];
         end

         // eight-bit rotate right, written back, carry untouched
         `RSA_OP_RR_CIRCULAR: begin
            mem_we_d    = 1'b1;
            mem_wdata_d = {i_mem_data[0], i_mem_data[7:1]}; // RULE_02
         end

         // eight-bit rotate right into work
         `RSA_OP_RR_TO_WORK: begin
            work_d = {i_mem_data[0], i_mem_data[7:1]}; // RULE_03
         end

         // nine-bit rotate right through carry, written back
         `RSA_OP_RR_THRU_C: begin
            mem_we_d            = 1'b1;
            mem_wdata_d         = {carry, i_mem_data[7:1]}; // RULE_04
            flags_d[`RSA_FLG_C] = i_mem_data[0];
         end

         // nine-bit rotate right through carry into work
         `RSA_OP_RR_THRU_C_TO_WORK: begin
            work_d              = {carry, i_mem_data[7:1]}; // RULE_05
            flags_d[`RSA_FLG_C] = i_mem_data[0];
         end

         // subtracts whose difference goes to memory
         `RSA_OP_SUB_BORROW_TO_MEM,
         `RSA_OP_DIFF_TO_MEM: begin
            mem_we_d    = 1'b1;
            mem_wdata_d = diff; // RULE_08 RULE_09
         end

         // subtracts whose difference goes to work
         `RSA_OP_SUB_BORROW_MEM,
         `RSA_OP_SUB_BORROW_IMM,
         `RSA_OP_SUB_MEM,
         `RSA_OP_SUB_IMM: begin
            work_d = diff; // RULE_06 RULE_07 RULE_09
         end

         // decrement written back, skip when it reaches zero
         `RSA_OP_DEC_SKIP: begin
            mem_we_d    = 1'b1;
            mem_wdata_d = i_mem_data - 8'h01; // RULE_12
            is_skip_op  = 1'b1;
            skip_d      = (i_mem_data == 8'h01);
         end

         // decrement into work, skip when it reaches zero
         `RSA_OP_DEC_SKIP_TO_WORK: begin
            work_d     = i_mem_data - 8'h01; // RULE_13
            is_skip_op = 1'b1;
            skip_d     = (i_mem_data == 8'h01);
         end

         // increment written back, skip when it wraps to zero
         `RSA_OP_INC_SKIP: begin
            mem_we_d    = 1'b1;
            mem_wdata_d = i_mem_data + 8'h01; // RULE_14
            is_skip_op  = 1'b1;
            skip_d      = (i_mem_data == `RSA_ALL_ONES);
         end

         // increment into work, skip when it wraps to zero
         `RSA_OP_INC_SKIP_TO_WORK: begin
            work_d     = i_mem_data + 8'h01; // RULE_15
            is_skip_op = 1'b1;
            skip_d     = (i_mem_data == `RSA_ALL_ONES);
         end

         // whole byte forced to ones
         `RSA_OP_SET_BYTE: begin
            mem_we_d    = 1'b1;
            mem_wdata_d = `RSA_ALL_ONES; // RULE_17
         end

         // one selected bit forced to one
         `RSA_OP_SET_BIT: begin
            mem_we_d    = 1'b1;
            mem_wdata_d = i_mem_data | bit_mask; // RULE_17
         end

         // skip on a set selected bit
         `RSA_OP_SKIP_BIT_NONNULL: begin
            is_skip_op = 1'b1;
            skip_d     = |(i_mem_data & bit_mask); // RULE_18
         end

         // skip on a non-zero byte
         `RSA_OP_SKIP_NONNULL: begin
            is_skip_op = 1'b1;
            skip_d     = |i_mem_data; // RULE_19
         end

         // skip on a zero byte
         `RSA_OP_SKIP_NULL: begin
            is_skip_op = 1'b1;
            skip_d     = ~|i_mem_data; // RULE_20
         end

         // copy to work, skip on a zero byte
         `RSA_OP_SKIP_NULL_TO_WORK: begin
            work_d     = i_mem_data;
            is_skip_op = 1'b1;
            skip_d     = ~|i_mem_data; // RULE_20
         end

         // nibble swap written back
         `RSA_OP_NIBBLE_EXCH: begin
            mem_we_d    = 1'b1;
            mem_wdata_d = {i_mem_data[3:0], i_mem_data[7:4]}; // RULE_21
         end

         // nibble swap into work
         `RSA_OP_NIBBLE_EXCH_TO_WRK: begin
            work_d = {i_mem_data[3:0], i_mem_data[7:4]}; // RULE_22
         end

         // unused codes act as single-cycle no-ops
         default: begin
            work_d = work_q;
         end
      endcase
      // all subtract forms share the six flag updates
      if (sub_op) begin
         flags_d[`RSA_FLG_C]  = ~diff9[8]; // RULE_10
         flags_d[`RSA_FLG_Z]  = ~|diff; // RULE_11
         flags_d[`RSA_FLG_AC] = ~diff_lo[4];
         flags_d[`RSA_FLG_OV] = (work_q[7] ^ sub_b[7]) & (diff[7] ^ work_q[7]);
         flags_d[`RSA_FLG_SC] = flags_d[`RSA_FLG_OV] ^ diff[7];
         flags_d[`RSA_FLG_CZ] = sub_keep_cz ? (~|diff & flags_q[`RSA_FLG_CZ]) : ~|diff;
      end
   end

   // apb decode: zero-wait slave, error on unmapped offsets
   assign o_pready  = 1'b1;
   assign apb_hit   = (i_paddr == `RSA_REG_WORK) | (i_paddr == `RSA_REG_FLAGS) |
                      (i_paddr == `RSA_REG_CTRL) | (i_paddr == `RSA_REG_STATUS);
   assign o_pslverr = i_psel & i_penable & ~apb_hit;
   assign apb_wr    = i_psel & i_penable & i_pwrite & apb_hit;

   // read data mux
   always @* begin
      case (i_paddr)
         `RSA_REG_WORK:   rd_mux = {24'h000000, work_q};
         `RSA_REG_FLAGS:  rd_mux = {26'h0, flags_q};
         `RSA_REG_CTRL:   rd_mux = {31'h0, enable_q};
         `RSA_REG_STATUS: rd_mux = {30'h0, skip_pend_q, dummy_q};
         default:         rd_mux = 32'h00000000;
      endcase
   end

   // read data captured in the setup phase, so it stands from a flip-flop
   // for the whole access phase; a state change at that same edge reads old
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_prdata <= 32'h00000000;
      end else if (i_psel && !i_penable) begin
         o_prdata <= rd_mux;
      end
   end

   // architectural state: executed instruction wins over a software write
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         work_q  <= `RSA_WORK_RST;
         flags_q <= `RSA_FLAGS_RST;
      end else if (take && !skip_pend_q) begin
         work_q  <= work_d;
         flags_q <= flags_d;
      end else if (apb_wr && i_paddr == `RSA_REG_WORK) begin
         work_q <= i_pwdata[7:0];
      end else if (apb_wr && i_paddr == `RSA_REG_FLAGS) begin
         flags_q <= i_pwdata[5:0];
      end
   end

   // control register
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         enable_q <= `RSA_CTRL_RST;
      end else if (apb_wr && i_paddr == `RSA_REG_CTRL) begin
         enable_q <= i_pwdata[0];
      end
   end

   // skip sequencing: dummy cycle, then squash the following instruction
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         dummy_q     <= 1'b0;
         skip_pend_q <= 1'b0;
         o_squash_q  <= 1'b0;
         o_skip_q    <= 1'b0;
      end else begin
         dummy_q    <= take & ~skip_pend_q & is_skip_op; // RULE_16
         o_skip_q   <= take & ~skip_pend_q & skip_d;
         o_squash_q <= take & skip_pend_q; // RULE_23
         if (take && skip_pend_q) begin
            skip_pend_q <= 1'b0; // RULE_23
         end else if (take && skip_d) begin
            skip_pend_q <= 1'b1;
         end
      end
   end

   // memory write port, suppressed for a skipped instruction
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_mem_we_q    <= 1'b0;
         o_mem_wdata_q <= 8'h00;
      end else begin
         o_mem_we_q <= take & ~skip_pend_q & mem_we_d; // RULE_23
         if (take && !skip_pend_q) begin
            o_mem_wdata_q <= mem_wdata_d;
         end
      end
   end

endmodule // rsa_alu

/* File: verification/rsa_alu_chk.sv */
`timescale 1ns/100ps
// watches the alu ports for datapath and skip sequencing slips
module rsa_alu_chk (
   // clock, reset and apb
   input wire logic        i_core_clk, i_rst, i_psel, i_penable, i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata, o_prdata,
   input wire logic        o_pready, o_pslverr,
   // instruction side
   input wire logic        i_op_valid, o_op_ready, o_mem_we_q, o_skip_q, o_squash_q,
   input wire logic [4:0]  i_op_code,
   input wire logic [2:0]  i_bit_sel,
   input wire logic [7:0]  i_mem_data, i_imm, o_mem_wdata_q, o_work_q,
   input wire logic [5:0]  o_flags_q
);
   logic pend_q, pend_d, take, live, cy, m0, m7, skty;
   // a pending skip swallows the next accepted instruction
   assign take = i_op_valid && o_op_ready;
   assign live = take && !pend_q;
   assign pend_d = take ? 1'b0 : (pend_q || o_skip_q);
   assign cy = o_flags_q[0];
   assign m0 = i_mem_data[0];
   assign m7 = i_mem_data[7];
   assign skty = (i_op_code >= 5'h0b && i_op_code <= 5'h0e) ||
                 (i_op_code >= 5'h11 && i_op_code <= 5'h14);
   // skip owed flag
   always @(posedge i_core_clk) begin
      pend_q <= i_rst ? 1'b0 : pend_d;
   end
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   sequence s_gap; !o_op_ready ##1 o_op_ready; endsequence
   property p_gap; live && skty |=> s_gap; endproperty
   property p_dec; live && i_op_code == 5'h0b |=> o_mem_we_q &&
      o_mem_wdata_q == $past(i_mem_data) - 8'h01 && o_skip_q == (o_mem_wdata_q == 8'h00);
   endproperty
   property p_inc; live && i_op_code == 5'h0e |=> !o_mem_we_q &&
      o_work_q == $past(i_mem_data) + 8'h01 && o_skip_q == (o_work_q == 8'h00);
   endproperty
   property p_rrc; live && i_op_code == 5'h03 |=> o_mem_we_q && cy == $past(m0) &&
      o_mem_wdata_q == ({$past(cy), 7'h00} | ($past(i_mem_data) >> 1)); endproperty
   property p_rotate_left_thru_carry_to_work; live && i_op_code == 5'h00 |=> !o_mem_we_q && cy == $past(m7) &&
      o_work_q == (($past(i_mem_data) << 1) | {7'h00, $past(cy)}); endproperty
   property p_sub; live && i_op_code == 5'h08 |=> o_work_q == $past(o_work_q) -
      $past(i_mem_data) && cy == ($past(o_work_q) >= $past(i_mem_data)); endproperty
   property p_set; live && i_op_code == 5'h0f |=> o_mem_we_q &&
      o_mem_wdata_q == 8'hff && $stable(o_flags_q); endproperty
   property p_squash; take && pend_q |=> o_squash_q && !o_mem_we_q &&
      $stable(o_work_q) && $stable(o_flags_q); endproperty
   a_gap: assert property (p_gap) else $error("no single dummy cycle");
   a_dec: assert property (p_dec) else $error("bad decrement skip");
   a_inc: assert property (p_inc) else $error("bad increment to work");
   a_rrc: assert property (p_rrc) else $error("bad rotate thru carry");
   a_rotate_left_thru_carry_to_work: assert property (p_rotate_left_thru_carry_to_work) else $error("bad rotate left to work");
   a_sub: assert property (p_sub) else $error("bad subtract carry");
   a_set: assert property (p_set) else $error("bad byte set");
   a_squash: assert property (p_squash) else $error("skipped op had effect");
endmodule // rsa_alu_chk
bind rsa_alu rsa_alu_chk rsa_alu_chk_inst (.i_core_clk, .i_rst, .i_psel, .i_penable,
   .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_op_valid,
   .o_op_ready, .o_mem_we_q, .o_skip_q, .o_squash_q, .i_op_code, .i_bit_sel,
   .i_mem_data, .i_imm, .o_mem_wdata_q, .o_work_q, .o_flags_q);

/* File: verification/rsa_seq_model.sv */
`timescale 1ns/100ps
// data memory beside the alu: eight bytes, written back one cycle after the take
module rsa_seq_model (
   input  wire logic       i_core_clk,
   input  wire logic       i_take,
   input  wire logic [2:0] i_addr,
   input  wire logic       i_mem_we,
   input  wire logic [7:0] i_wdata,
   output wire logic [7:0] o_rdata
);
   logic [7:0] mem_q [8] = '{8'h01, 8'h00, 8'hff, 8'h81, 8'h5a, 8'h3c, 8'h7f, 8'h80};
   logic [2:0] addr_q = 3'h0;
   // operand read is combinational; the write lands at the taken address
   assign o_rdata = mem_q[i_addr];
   always @(posedge i_core_clk) begin
      if (i_take) addr_q <= i_addr;
      if (i_mem_we) mem_q[addr_q] <= i_wdata;
   end
endmodule // rsa_seq_model

/* File: verification/rsa_alu_tb.sv */
`timescale 1ns/100ps
`include "rsa_map.vh"
`define RSA_CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
   $display("unexpected at %0t: got %h want %h", $time, g, e); end end
// drives every operation code through the alu and its data memory
module rsa_alu_tb;
   // design inputs
   logic        i_core_clk = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0;
   logic        i_pwrite = 1'b0, i_op_valid = 1'b0, perr;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0, rd;
   logic [4:0]  i_op_code = 5'h00;
   logic [7:0]  i_imm = 8'h00;
   logic [2:0]  i_bit_sel = 3'h0, addr = 3'h0;
   // design outputs
   wire logic [31:0] o_prdata;
   wire logic        o_pready, o_pslverr, o_op_ready, o_mem_we_q, o_skip_q, o_squash_q;
   wire logic [7:0]  o_mem_wdata_q, o_work_q, mem_rd;
   wire logic [5:0]  o_flags_q;
   int errors = 0, total_checks = 0;
   // op, addr, imm or bit, work in, carry in, work out, {dummy,write,skip,carry}, mem out
   logic [51:0] rows [24] = '{
      52'h00_3_00_00_0_02_1_00, 52'h01_5_00_00_1_00_5_1e, 52'h02_3_00_00_0_c0_0_00,
      52'h03_4_00_00_1_00_4_ad, 52'h04_3_00_00_0_40_1_00, 52'h05_5_00_10_0_f1_0_00,
      52'h06_0_20_50_1_30_1_00, 52'h07_1_00_05_0_05_5_04, 52'h08_6_00_7f_0_00_1_00,
      52'h09_0_01_00_1_ff_0_00, 52'h0a_7_00_80_0_80_5_00, 52'h0b_0_00_00_0_00_e_00,
      52'h0c_2_00_00_0_fe_8_00, 52'h0d_2_00_00_0_00_e_00, 52'h0e_4_00_00_0_ae_8_00,
      52'h0f_6_00_00_0_00_4_ff, 52'h10_3_04_00_0_00_4_91, 52'h11_3_00_00_0_00_a_00,
      52'h12_0_00_00_0_00_8_00, 52'h12_1_00_00_0_00_a_00, 52'h13_0_00_00_0_00_a_00,
      52'h14_5_00_00_0_1e_8_00, 52'h15_4_00_00_0_00_4_da, 52'h16_5_00_00_0_e1_0_00};
   rsa_alu rsa_alu_inst (.i_core_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
      .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_op_valid, .i_op_code,
      .i_mem_data(mem_rd), .i_imm, .i_bit_sel, .o_op_ready, .o_mem_we_q,
      .o_mem_wdata_q, .o_skip_q, .o_squash_q, .o_work_q, .o_flags_q);
   rsa_seq_model rsa_seq_model_inst (.i_core_clk, .i_take(i_op_valid && o_op_ready),
      .i_addr(addr), .i_mem_we(o_mem_we_q), .i_wdata(o_mem_wdata_q), .o_rdata(mem_rd));
   always #20 i_core_clk = ~i_core_clk;
   // verdict and end of run
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // one apb transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge i_core_clk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_core_clk);
      i_penable <= 1'b1;
      do begin @(posedge i_core_clk); n++; end while (o_pready !== 1'b1 && n < 20);
      if (o_pready !== 1'b1) begin errors++; stop_test; end
      rd = o_prdata;
      perr = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask
   // one instruction, held until accepted; returns with results settled
   task automatic op(input logic [4:0] c, input logic [2:0] a, input logic [7:0] x);
      int n = 0;
      @(posedge i_core_clk);
      i_op_valid <= 1'b1;
      i_op_code <= c;
      addr <= a;
      i_imm <= x;
      i_bit_sel <= x[2:0];
      do begin @(posedge i_core_clk); n++; end while (o_op_ready !== 1'b1 && n < 20);
      if (o_op_ready !== 1'b1) begin errors++; stop_test; end
      i_op_valid <= 1'b0;
      @(negedge i_core_clk);
   endtask
   // reset, table of operations, then the awkward cases
   initial begin
      logic [51:0] w;
      repeat (2) @(posedge i_core_clk);
      i_rst <= 1'b0;
      @(negedge i_core_clk);
      `RSA_CHK(o_work_q, 8'h00)
      `RSA_CHK(o_flags_q, 6'h00)
      apb(1'b0, `RSA_REG_CTRL, 32'h0);
      `RSA_CHK(rd, 32'h1)
      apb(1'b0, 12'h010, 32'h0);
      `RSA_CHK(perr, 1'b1)
      $display("reset and bus test done");
      foreach (rows[i]) begin
         w = rows[i];
         apb(1'b1, `RSA_REG_WORK, {24'h0, w[31:24]});
         apb(1'b1, `RSA_REG_FLAGS, {31'h0, w[20]});
         op(w[48:44], w[42:40], w[39:32]);
         `RSA_CHK(o_work_q, w[19:12])
         `RSA_CHK(o_flags_q[0], w[8])
         `RSA_CHK(o_mem_we_q, w[10])
         `RSA_CHK(o_skip_q, w[9])
         `RSA_CHK(o_op_ready, !w[11])
         if (w[10]) `RSA_CHK(o_mem_wdata_q, w[7:0])
         op(5'h17, 3'h0, 8'h00);
         `RSA_CHK(o_squash_q, w[9])
      end
      $display("operation table done");
      op(`RSA_OP_SKIP_NULL, 3'h0, 8'h00);
      op(`RSA_OP_SET_BYTE, 3'h1, 8'h00);
      `RSA_CHK(o_squash_q, 1'b1)
      `RSA_CHK(o_mem_we_q, 1'b0)
      op(`RSA_OP_SKIP_NULL_TO_WORK, 3'h1, 8'h00);
      `RSA_CHK(o_work_q, 8'h04)
      $display("squash test done");
      apb(1'b1, `RSA_REG_WORK, 32'h7f);
      apb(1'b1, `RSA_REG_FLAGS, 32'h0);
      op(`RSA_OP_SUB_IMM, 3'h0, 8'h7f);
      `RSA_CHK(o_flags_q, 6'h2b)
      apb(1'b0, `RSA_REG_FLAGS, 32'h0);
      `RSA_CHK(rd, 32'h2b)
      $display("flag test done");
      op(`RSA_OP_SKIP_NULL, 3'h0, 8'h00);
      apb(1'b0, `RSA_REG_STATUS, 32'h0);
      `RSA_CHK(rd, 32'h2)
      apb(1'b1, `RSA_REG_CTRL, 32'h0);
      @(negedge i_core_clk);
      `RSA_CHK(o_op_ready, 1'b0)
      apb(1'b1, `RSA_REG_CTRL, 32'h1);
      op(5'h17, 3'h0, 8'h00);
      `RSA_CHK(o_squash_q, 1'b1)
      $display("status and enable test done");
      op(`RSA_OP_SKIP_NONNULL, 3'h1, 8'h00);
      @(posedge i_core_clk);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      i_rst <= 1'b0;
      @(negedge i_core_clk);
      `RSA_CHK(o_flags_q, 6'h00)
      `RSA_CHK(o_op_ready, 1'b1)
      op(5'h17, 3'h0, 8'h00);
      `RSA_CHK(o_squash_q, 1'b0)
      $display("mid-run reset test done");
      stop_test;
   end
endmodule // rsa_alu_tb
